/* File: src/irendc_params.svh */
`ifndef IRENDC_PARAMS_SVH
`define IRENDC_PARAMS_SVH

// Register indices; byte address is four times the index
`define IRD_CTRL_IDX 10'h0BF
`define IRD_STAT_IDX 10'h0C0
`define IRD_ADDR_W 12
`define IRD_CTRL_RST 8'h00
`define IRD_CTRL_WMASK 8'hF7
`define IRD_FACTOR_OFF 4'h0
// Divider low bits are fixed
`define IRD_DIV_LOW 2'h3
// Baud-clock positions within a 16-clock bit
`define IRD_LAST_TICK 4'hF
`define IRD_TX_HI_START 4'h7
`define IRD_TX_HI_END 4'h9
`define IRD_RX_EDGE_PHASE 4'h7
`define IRD_RX_QUAL_PHASE 4'hA
// Longest legal low pulse, in baud clocks
`define IRD_MAX_LOW_TICKS 3'h5
// Run of idle bits that ends a frame
`define IRD_IDLE_BITS 4'hA
`define IRD_BUF_DEPTH 2

`endif

/* File: src/irendc_pkg.sv */
package irendc_pkg;

  typedef struct packed {
    logic [3:0] factor;
    logic rsvd;
    logic loopback;
    logic rxen;
    logic en;
  } irendc_ctrl_t;

  typedef struct packed {
    logic [3:0] zero;
    logic [1:0] fill;
    logic out_busy;
    logic frame;
  } irendc_stat_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_FRAME = 2'b01,
    RX_HOLD = 2'b10
  } irendc_rx_state_t;

endpackage

/* File: src/irendc_buf2.sv */
`timescale 1ns/1ns
`include "irendc_params.svh"

module irendc_buf2 #(
  parameter int WIDTH = 1,
  parameter int DEPTH = `IRD_BUF_DEPTH
) (
  input wire logic i_clock, // System clock
  input wire logic i_sys_rst, // Sync reset, active high
  input wire logic i_flush, // Drop contents
  input wire logic i_in_valid, // Fill side offers a word
  output logic o_in_ready, // Room for a word
  input wire logic [WIDTH-1:0] i_in_data, // Word in
  output logic o_out_valid, // Word available
  input wire logic i_out_ready, // Drain side takes it
  output logic [WIDTH-1:0] o_out_data, // Oldest word
  output logic [1:0] o_fill // Words held
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic rd_ptr_q;
  logic wr_ptr_q;
  logic [1:0] fill_q;
  logic push;
  logic pop;

  assign o_in_ready = (fill_q != 2'(DEPTH));
  assign o_out_valid = (fill_q != 2'h0);
  assign o_out_data = mem_q[rd_ptr_q];
  assign o_fill = fill_q;
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst || i_flush) begin
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      fill_q <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push && !pop) begin
        fill_q <= fill_q + 2'h1;
      end else if (pop && !push) begin
        fill_q <= fill_q - 2'h1;
      end
    end
  end

endmodule // irendc_buf2

/* File: src/irendc_top.sv */
`timescale 1ns/1ns
`include "irendc_params.svh"

module irendc_top
  import irendc_pkg::*;
(
  input wire logic i_clock, // System clock
  input wire logic i_sys_rst, // Sync reset, active high
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB access phase
  input wire logic i_pwrite, // APB direction
  input wire logic [`IRD_ADDR_W-1:0] i_paddr, // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  output logic [31:0] o_prdata, // APB read data
  output logic o_pready, // APB ready
  output logic o_pslverr, // APB error, unmapped address
  input wire logic i_baud_tick, // One pulse per baud clock
  input wire logic i_uart_txd, // UART transmit line
  output logic o_uart_rxd, // UART receive line
  input wire logic i_optical_rx_in, // From transceiver, idle high
  output logic o_optical_tx_out // To transceiver, idle low while enabled; follows i_uart_txd when disabled
);

  // Saturating increment shared by the pulse timer and the idle run
  function automatic logic [3:0] sat_inc(input logic [3:0] v);
    return (v == 4'hF) ? v : v + 4'h1;
  endfunction

  irendc_ctrl_t ctrl_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [9:0] word_idx;
  logic hit_ctrl;
  logic hit_stat;
  logic wr_done;

  logic act;
  logic encode;
  logic edge_mode;
  logic [5:0] div_val;
  logic [5:0] div_cnt_q;
  logic min_met_q;
  logic [3:0] low_ticks_q;
  logic rx_line;
  logic rx_prev_q;
  logic fall;
  logic rise;
  logic qual;

  irendc_rx_state_t state_q;
  logic [3:0] phase_q;
  logic seen_q;
  logic bit_q;
  logic [3:0] ones_q;
  logic bit_end;

  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic buf_out_data;
  logic [1:0] buf_fill;
  logic out_busy_q;
  logic [3:0] out_cnt_q;
  logic uart_rxd_q;

  logic txd_prev_q;
  logic [3:0] tx_tick_q;
  logic tx_bit_q;
  logic tx_out_q;

  // APB slave: one wait state so read data leaves a flip-flop
  assign word_idx = i_paddr[`IRD_ADDR_W-1:2];
  assign hit_ctrl = (word_idx == `IRD_CTRL_IDX);
  assign hit_stat = (word_idx == `IRD_STAT_IDX);
  assign wr_done = i_psel & i_penable & pready_q & i_pwrite & hit_ctrl;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= i_psel & i_penable & ~pready_q;
      pslverr_q <= i_psel & i_penable & ~pready_q & ~(hit_ctrl | hit_stat);
      if (i_psel && i_penable && !pready_q && !i_pwrite) begin
        if (hit_ctrl) begin
          prdata_q <= {24'h00_0000, ctrl_q};
        end else if (hit_stat) begin
          prdata_q <= {24'h00_0000, irendc_stat_t'({4'h0, buf_fill, out_busy_q,
                                                    state_q != RX_IDLE})};
        end else begin
          prdata_q <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ctrl_q <= irendc_ctrl_t'(`IRD_CTRL_RST);
    end else if (wr_done) begin
      ctrl_q <= irendc_ctrl_t'(i_pwdata[7:0] & `IRD_CTRL_WMASK);
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;

  assign act = ctrl_q.en & ctrl_q.rxen;
  assign encode = ctrl_q.en & (~ctrl_q.rxen | ctrl_q.loopback);
  assign edge_mode = (ctrl_q.factor == `IRD_FACTOR_OFF);
  assign div_val = {ctrl_q.factor, `IRD_DIV_LOW};
  assign rx_line = ctrl_q.loopback ? ~tx_out_q : i_optical_rx_in;
  assign fall = rx_prev_q & ~rx_line;
  assign rise = ~rx_prev_q & rx_line;
  // Width mode judges at the rising edge, after both limits are known
  assign qual = act & (edge_mode ? fall :
                (rise & min_met_q & (low_ticks_q <= 4'(`IRD_MAX_LOW_TICKS))));

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_line;
    end
  end

  // Divider restarts on each falling edge so the first period is whole
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || rx_line || edge_mode) begin
      div_cnt_q <= 6'h00;
      min_met_q <= 1'b0;
      low_ticks_q <= 4'h0;
    end else if (fall) begin
      // Edge cycle is already low, so a pulse of one whole period qualifies
      div_cnt_q <= 6'h01;
      min_met_q <= 1'b0;
      low_ticks_q <= 4'h0;
    end else begin
      if (div_cnt_q == div_val) begin
        div_cnt_q <= 6'h00;
        min_met_q <= 1'b1;
      end else begin
        div_cnt_q <= div_cnt_q + 6'h01;
      end
      if (i_baud_tick) begin
        low_ticks_q <= sat_inc(low_ticks_q);
      end
    end
  end

  assign bit_end = (state_q == RX_FRAME) & i_baud_tick & (phase_q == `IRD_LAST_TICK);

  // Decoder: a qualified pulse anywhere in the bit makes it a 0
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || !act) begin
      state_q <= RX_IDLE;
      phase_q <= 4'h0;
      seen_q <= 1'b0;
      bit_q <= 1'b1;
      ones_q <= 4'h0;
    end else begin
      case (state_q)
        RX_IDLE: begin
          if (qual) begin
            // First bit aligns to the pulse, hence its jitter
            phase_q <= edge_mode ? `IRD_RX_EDGE_PHASE : `IRD_RX_QUAL_PHASE;
            seen_q <= 1'b1;
            ones_q <= 4'h0;
            state_q <= RX_FRAME;
          end
        end
        RX_FRAME: begin
          if (bit_end) begin
            bit_q <= ~(seen_q | qual);
            seen_q <= 1'b0;
            phase_q <= 4'h0;
            ones_q <= (seen_q | qual) ? 4'h0 : sat_inc(ones_q);
            state_q <= RX_HOLD;
          end else begin
            if (qual) begin
              seen_q <= 1'b1;
            end
            if (i_baud_tick) begin
              phase_q <= phase_q + 4'h1;
            end
          end
        end
        RX_HOLD: begin
          // Decoder stalls until the buffer takes the bit
          if (qual) begin
            seen_q <= 1'b1;
          end
          if (buf_in_ready) begin
            state_q <= (ones_q >= `IRD_IDLE_BITS) ? RX_IDLE : RX_FRAME;
          end
        end
        default: begin
          state_q <= RX_IDLE;
        end
      endcase
    end
  end

  irendc_buf2 #(
    .WIDTH(1),
    .DEPTH(`IRD_BUF_DEPTH)
  ) u_buf (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_flush(~act),
    .i_in_valid(state_q == RX_HOLD),
    .o_in_ready(buf_in_ready),
    .i_in_data(bit_q),
    .o_out_valid(buf_out_valid),
    .i_out_ready(buf_out_ready),
    .o_out_data(buf_out_data),
    .o_fill(buf_fill)
  );

  assign buf_out_ready = act & (~out_busy_q | (i_baud_tick & (out_cnt_q == `IRD_LAST_TICK)));

  // UART side: each buffered bit holds until the 16th baud clock after it is loaded
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      out_busy_q <= 1'b0;
      out_cnt_q <= 4'h0;
      uart_rxd_q <= 1'b1;
    end else if (!ctrl_q.en) begin
      out_busy_q <= 1'b0;
      uart_rxd_q <= i_optical_rx_in;
    end else if (!ctrl_q.rxen) begin
      out_busy_q <= 1'b0;
      uart_rxd_q <= 1'b1;
    end else if (buf_out_ready && buf_out_valid) begin
      out_busy_q <= 1'b1;
      out_cnt_q <= 4'h0;
      uart_rxd_q <= buf_out_data;
    end else if (out_busy_q && i_baud_tick) begin
      if (out_cnt_q == `IRD_LAST_TICK) begin
        out_busy_q <= 1'b0;
        uart_rxd_q <= 1'b1;
      end else begin
        out_cnt_q <= out_cnt_q + 4'h1;
      end
    end
  end

  assign o_uart_rxd = uart_rxd_q;

  // Encoder resyncs its bit clock on every UART transmit edge
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      txd_prev_q <= 1'b1;
      tx_tick_q <= 4'h0;
      tx_bit_q <= 1'b1;
      tx_out_q <= 1'b0;
    end else begin
      txd_prev_q <= i_uart_txd;
      if (i_uart_txd != txd_prev_q) begin
        tx_tick_q <= 4'h0;
        tx_bit_q <= i_uart_txd;
      end else if (i_baud_tick) begin
        tx_tick_q <= tx_tick_q + 4'h1;
        if (tx_tick_q == `IRD_LAST_TICK) begin
          tx_bit_q <= i_uart_txd;
        end
      end
      if (!ctrl_q.en) begin
        tx_out_q <= i_uart_txd;
      end else if (!encode) begin
        tx_out_q <= 1'b0;
      end else begin
        tx_out_q <= ~tx_bit_q & (tx_tick_q >= `IRD_TX_HI_START) &
                    (tx_tick_q <= `IRD_TX_HI_END);
      end
    end
  end

  assign o_optical_tx_out = tx_out_q;

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  sequence s_ctrl_write;
    i_psel && i_penable && pready_q && i_pwrite && hit_ctrl;
  endsequence

  sequence s_zero_high;
    encode && !tx_bit_q && (tx_tick_q == `IRD_TX_HI_START) && (i_uart_txd == txd_prev_q);
  endsequence

  AST_RSVD_ZERO: assert property (ctrl_q.rsvd == 1'b0)
    else $error("reserved control bit set");
  AST_FACTOR_WRITE: assert property (s_ctrl_write |=>
      ctrl_q.factor == $past(i_pwdata[7:4]))
    else $error("factor field not written");
  AST_DIV_PERIOD: assert property ($rose(min_met_q) |->
      $past(div_cnt_q) == {ctrl_q.factor, `IRD_DIV_LOW})
    else $error("divider period wrong");
  AST_EDGE_START: assert property ((act && edge_mode && fall && state_q == RX_IDLE) |=>
      (state_q == RX_FRAME && phase_q == `IRD_RX_EDGE_PHASE))
    else $error("edge mode did not start a frame");
  AST_LONG_REJECT: assert property ((act && !edge_mode && state_q == RX_IDLE && rise &&
      low_ticks_q > 4'(`IRD_MAX_LOW_TICKS)) |=> state_q == RX_IDLE)
    else $error("overlong pulse accepted");
  AST_RX_GATED: assert property ((ctrl_q.en && !ctrl_q.rxen) [*2] |-> o_uart_rxd)
    else $error("receive line not ignored");
  AST_BIT_WIDTH: assert property ((out_busy_q && buf_out_ready && buf_out_valid) |->
      (i_baud_tick && out_cnt_q == `IRD_LAST_TICK))
    else $error("bit shorter than 16 baud clocks");
  AST_ONE_BIT: assert property ((bit_end && !seen_q && !qual) |=>
      (state_q == RX_HOLD && bit_q))
    else $error("quiet bit not decoded as one");
  AST_ZERO_SHAPE: assert property (s_zero_high ##1 (ctrl_q.en && encode) |->
      o_optical_tx_out)
    else $error("zero bit pulse missing");
  AST_LOOP_INVERT: assert property ((ctrl_q.loopback && $rose(tx_out_q)) |=> !rx_prev_q)
    else $error("loopback not inverted");
  AST_PASS_THRU: assert property ((!ctrl_q.en) [*2] |->
      o_optical_tx_out == $past(i_uart_txd))
    else $error("disabled path not transparent");

endmodule // irendc_top

/* File: dv/irendc_ir_xcvr.sv */
`timescale 1ns/1ns

module irendc_ir_xcvr (
  input wire logic i_clock, // System clock
  input wire logic i_baud_tick, // Baud clock pulse
  input wire logic i_send, // Start a frame when idle
  input wire logic [7:0] i_byte, // Byte to send
  output logic o_line // Optical line, idle high
);
  logic [9:0] sh_q = 10'h0;
  logic [3:0] tk_q = 4'h0;
  logic [3:0] nb_q = 4'h0;

  always @(posedge i_clock) begin
    if (nb_q == 4'h0) begin
      if (i_send) begin
        sh_q <= {1'h1, i_byte, 1'h0};
        nb_q <= 4'hA;
        tk_q <= 4'h0;
      end
    end else if (i_baud_tick) begin
      tk_q <= tk_q + 4'h1;
      if (tk_q == 4'hF) begin
        sh_q <= sh_q >> 1;
        nb_q <= nb_q - 4'h1;
      end
    end
  end

  // Exactly three tick periods low, the boundary of a legal pulse
  assign o_line = !(nb_q != 4'h0 && !sh_q[0] && tk_q >= 4'h7 && tk_q <= 4'h9);
endmodule // irendc_ir_xcvr

/* File: dv/irendc_top_test.sv */
`timescale 1ns/1ns
`include "irendc_params.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, e); end end

module irendc_top_test;
  localparam int P = 4;
  localparam logic [11:0] A_CTL = {`IRD_CTRL_IDX, 2'h0};
  localparam logic [11:0] A_STAT = {`IRD_STAT_IDX, 2'h0};
  logic i_clock = 0, i_sys_rst = 1, psel = 0, pen = 0, pwr = 0, tick = 0, txd = 1, send = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] sbyte = 8'h0;
  logic [1:0] tcnt = 2'h0;
  logic [9:0] fr;
  logic pready, pslverr, rxd, txo, line, err;
  bit got;
  int num_errors = 0, n_compared = 0, hi;

  always #4 i_clock = ~i_clock;
  // Baud tick every P system clocks
  always @(posedge i_clock) begin
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
  end

  irendc_top u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_baud_tick(tick), .i_uart_txd(txd), .o_uart_rxd(rxd),
    .i_optical_rx_in(line), .o_optical_tx_out(txo));
  irendc_ir_xcvr u_xcvr (.i_clock(i_clock), .i_baud_tick(tick), .i_send(send),
    .i_byte(sbyte), .o_line(line));

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge i_clock);
    pen <= 1;
    do begin @(posedge i_clock); n++; end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 0; pen <= 0;
  endtask

  // Samples mid-bit, so each bit must hold its 16 ticks
  task automatic rx_frame;
    int n;
    got = 0;
    n = 0;
    while (rxd !== 1'h0 && n < 1000) begin @(negedge i_clock); n++; end
    if (rxd === 1'h0) begin
      got = 1;
      repeat (8 * P) @(negedge i_clock);
      for (int i = 0; i < 10; i++) begin
        fr[i] = rxd;
        repeat (16 * P) @(negedge i_clock);
      end
    end
  endtask

  task automatic ir_rx(input logic [7:0] c, input logic [7:0] b);
    apb(1, A_CTL, {24'h0, c});
    sbyte <= b; send <= 1;
    @(posedge i_clock);
    send <= 0;
    rx_frame;
    repeat (12 * 16 * P) @(posedge i_clock);
  endtask

  task automatic tx_bit(input logic b);
    hi = 0;
    @(posedge i_clock);
    txd <= b;
    repeat (16 * P + 4) begin @(negedge i_clock); hi += (txo === 1'h1); end
  endtask

  task automatic uart_tx(input logic [9:0] f);
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clock);
      txd <= f[i];
      repeat (16 * P - 1) @(posedge i_clock);
    end
  endtask

  task summarize;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge i_clock);
    num_errors++;
    summarize;
  end

  initial begin
    repeat (3) @(posedge i_clock);
    i_sys_rst <= 0;
    apb(0, A_CTL, 32'h0); `CHK(rd, 32'h0)
    apb(0, A_STAT, 32'h0); `CHK(rd, 32'h0)
    apb(1, A_CTL, 32'hFFFFFFFF); apb(0, A_CTL, 32'h0); `CHK(rd, 32'h000000F7)
    apb(0, 12'h004, 32'h0); `CHK(err, 1'h1)
    `CHK(rd, 32'h0)
    // Disabled: transmit line passes through unencoded
    apb(1, A_CTL, 32'h0);
    @(posedge i_clock);
    txd <= 0;
    @(posedge i_clock);
    @(negedge i_clock); `CHK(txo, 1'h0)
    @(posedge i_clock);
    txd <= 1;
    @(posedge i_clock);
    @(negedge i_clock); `CHK(txo, 1'h1)
    apb(1, A_CTL, 32'h01);
    tx_bit(0); `CHK(hi, 3 * P)
    tx_bit(1); `CHK(hi, 0)
    apb(1, A_CTL, 32'h03);
    tx_bit(0); `CHK(hi, 0)
    tx_bit(1);
    ir_rx(8'h03, 8'h5A); `CHK(got, 1'h1)
    `CHK(fr, {1'h1, 8'h5A, 1'h0})
    ir_rx(8'h23, 8'hC3); `CHK(got, 1'h1)
    `CHK(fr, {1'h1, 8'hC3, 1'h0})
    ir_rx(8'h33, 8'h3C); `CHK(got, 1'h0)
    ir_rx(8'h01, 8'h3C); `CHK(got, 1'h0)
    apb(1, A_CTL, 32'h07);
    fork
      uart_tx({1'h1, 8'hA5, 1'h0});
      rx_frame;
    join
    `CHK(fr, {1'h1, 8'hA5, 1'h0})
    summarize;
  end
endmodule // irendc_top_test
